/* File: dv/peak_code_tracker_sva.sv */
`timescale 1ns/1ps
module peak_code_tracker_sva (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic conv_valid, // Sample
   input wire logic reg_rd, // Read
   input wire logic reg_wr, // Write
   input wire logic [7:0] reg_addr, // Addr
   input wire logic [7:0] reg_rdata, // Data
   input wire logic reg_ack // Answer
);
   // Reset check lifts the disable
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd(a); reg_rd && !conv_valid && reg_addr == a; endsequence
   property p_ack; reg_rd || reg_wr |=> reg_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_clr; s_rd(8'h67) ##1 s_rd(8'h67) |=> reg_rdata == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_low; s_rd(8'h60) ##1 s_rd(8'h60) |=> reg_rdata == 8'h00; endproperty
   a_low: assert property (p_low) else $error("no clear");
   property p_rst; disable iff (1'b0) rst |-> reg_rdata == 8'h00 && !reg_ack; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_hole; reg_rd && reg_addr[7:3] != 5'h0C |=> reg_rdata == 8'h00; endproperty
   a_hole: assert property (p_hole) else $error("unmapped");
   property p_wr; reg_wr && !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_wr: assert property (p_wr) else $error("write");
endmodule

bind peak_code_tracker peak_code_tracker_sva sva (.*);

/* File: dv/peak_code_tracker_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t bad", $time); end end
module peak_code_tracker_tb;
   logic clk = 1'b0, rst, conv_valid = 1'b0, reg_rd, reg_wr, reg_ack;
   logic [2:0] conv_channel = 3'h0;
   logic [15:0] conv_code = 16'h0000, pk [4] = '{default: 16'h0000};
   logic [7:0] reg_addr, reg_rdata, d;
   logic [31:0] s = 32'h0E26;
   int failures = 0, tests_run = 0;
   initial forever #50 clk = ~clk; // 10 MHz
   peak_code_tracker DUT (.*);
   peak_host HOST (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Expected data; a mapped read also clears its byte
   function automatic logic [7:0] exp_rd(input logic w, input logic [7:0] a);
      exp_rd = 8'h00;
      if (!w && a[7:3] == 5'h0C) begin
         exp_rd = pk[a[2:1]][{a[0], 3'h0} +: 8];
         pk[a[2:1]][{a[0], 3'h0} +: 8] = 8'h00;
      end
   endfunction
   // One result; channels 4..7 are not tracked
   task cv(input logic [2:0] c, input logic [15:0] k);
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_channel <= c;
      conv_code <= k;
      @(posedge clk);
      conv_valid <= 1'b0;
      if (!c[2] && k > pk[c[1:0]]) pk[c[1:0]] = k;
   endtask
   // Access and compare; a lost answer ends the run
   task rc(input logic w, input logic [7:0] a);
      HOST.access(w, a, d);
      `CHK(d, exp_rd(w, a))
      if (d === 8'hXX) give_verdict();
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Corners first, then random traffic around the bank
   initial begin
      rst <= 1'b1; // Real rising edge, so the async reset fires before the first clock
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (logic [7:0] a = 8'h60; a < 8'h68; a++) rc(1'b0, a);
      cv(3'h0, 16'h00FF);
      rc(1'b0, 8'h60);
      rc(1'b0, 8'h60);
      cv(3'h3, 16'hFFFF);
      rc(1'b1, 8'h67);
      rc(1'b0, 8'h67);
      rc(1'b0, 8'h67);
      rc(1'b0, 8'h66);
      $display("directed done");
      repeat (500) begin
         s = lfsr(s);
         cv(s[2:0], s[18:3]);
         rc(s[19], 8'h5C + {4'h0, s[23:20]});
      end
      $display("random done");
      give_verdict();
   end
endmodule

/* File: dv/peak_host.sv */
`timescale 1ns/1ps
module peak_host (
   input wire logic clk, // Clock
   input wire logic reg_ack, // Answer
   input wire logic [7:0] reg_rdata, // Data
   output logic reg_rd = 1'b0, // Read
   output logic reg_wr = 1'b0, // Write
   output logic [7:0] reg_addr = 8'h00 // Addr
);
   // One-edge strobe, bounded wait; no answer gives unknown data
   task automatic access(input logic w, input logic [7:0] a, output logic [7:0] d);
      reg_rd <= !w;
      reg_wr <= w;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      for (int n = 0; n < 3 && !reg_ack; n++) @(posedge clk) #1;
      d = reg_ack ? reg_rdata : 8'hXX;
   endtask
endmodule

/* File: hw/peak_channel.sv */
`timescale 1ns/1ps

// Peak recorder for one channel, with per-byte clear on read
module peak_channel
   import peak_pkg::*;
(
   input wire logic clk, // Device clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic sample_valid, // New result for this channel
   input wire logic [PEAK_W-1:0] sample_code, // Conversion code
   input wire logic clr_low, // Low byte read this cycle
   input wire logic clr_high, // High byte read this cycle
   output logic [PEAK_W-1:0] peak // Recorded peak
);

   typedef struct packed {
      logic [PEAK_W-1:0] peak;
   } chan_state_t;

   chan_state_t state;
   chan_state_t next_state;
   logic [PEAK_W-1:0] base;

   // Clear first, then compare, so a sample in the read cycle is kept
   always_comb begin
      next_state = state;
      base = state.peak;
      if (clr_low) begin
         base[BYTE_W-1:0] = BYTE_CLEAR;
      end
      if (clr_high) begin
         base[PEAK_W-1:BYTE_W] = BYTE_CLEAR;
      end
      if (sample_valid && (sample_code > base)) begin
         next_state.peak = sample_code;
      end else begin
         next_state.peak = base;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state.peak <= PEAK_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign peak = state.peak;

endmodule

/* File: hw/peak_code_tracker.sv */
// Functional notes
// - Keep largest code per channel since read
// - Read returns value, then clears that byte
// - Reset zeroes all channel 0-3 peaks
// - Byte pairs at 0x60..0x67, low byte even
// - Channel 0 low byte at 0x60, read-clear
`timescale 1ns/1ps

module peak_code_tracker
   import peak_pkg::*;
(
   input wire logic clk, // Device clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic conv_valid, // One-cycle strobe, new result
   input wire logic [CONV_CH_W-1:0] conv_channel, // Channel of the result
   input wire logic [PEAK_W-1:0] conv_code, // Conversion code
   input wire logic reg_rd, // Register read strobe
   input wire logic reg_wr, // Register write strobe
   input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
   output logic [BYTE_W-1:0] reg_rdata, // Read data, held until next access
   output logic reg_ack // One-cycle access answer
);

   typedef struct packed {
      logic [BYTE_W-1:0] rdata;
      logic ack;
   } bus_state_t;

   bus_state_t state;
   bus_state_t next_state;
   peak_decode_t dec;
   logic [PEAK_W-1:0] peak [NUM_CH];
   logic [NUM_CH-1:0] clr_low;
   logic [NUM_CH-1:0] clr_high;
   logic [NUM_CH-1:0] sample_valid;

   // Map an address onto channel and byte; outside the block gives no hit
   function automatic peak_decode_t decode_addr(input logic [ADDR_W-1:0] addr);
      peak_decode_t d;
      logic [ADDR_W-1:0] off;
      off = addr - ADDR_PEAK_CH0_LOW;
      d.hit = (addr >= ADDR_PEAK_CH0_LOW) && (off < PEAK_SPAN);
      d.ch = off[CH_IDX_W:1];
      d.high = off[0];
      return d;
   endfunction

   // Pick one byte of a channel's peak
   function automatic logic [BYTE_W-1:0] pick_byte(input logic [PEAK_W-1:0] value, input logic high);
      logic [BYTE_W-1:0] b;
      if (high) begin
         b = value[PEAK_W-1:BYTE_W];
      end else begin
         b = value[BYTE_W-1:0];
      end
      return b;
   endfunction

   assign dec = decode_addr(reg_addr);

   // One recorder per channel; converter channels above 3 are not tracked here
   genvar i;
   generate
      for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
         assign sample_valid[i] = conv_valid && (conv_channel == CONV_CH_W'(i));
         assign clr_low[i] = reg_rd && dec.hit && (dec.ch == CH_IDX_W'(i)) && !dec.high;
         assign clr_high[i] = reg_rd && dec.hit && (dec.ch == CH_IDX_W'(i)) && dec.high;
         peak_channel u_chan (
            .clk(clk),
            .rst(rst),
            .sample_valid(sample_valid[i]),
            .sample_code(conv_code),
            .clr_low(clr_low[i]),
            .clr_high(clr_high[i]),
            .peak(peak[i])
         );
      end
   endgenerate

   // Read answer: the value before the clear, registered for one cycle of ack
   always_comb begin
      next_state = state;
      next_state.ack = reg_rd || reg_wr;
      if (reg_rd) begin
         if (dec.hit) begin
            next_state.rdata = pick_byte(peak[dec.ch], dec.high);
         end else begin
            next_state.rdata = RDATA_UNMAPPED;
         end
      end else if (reg_wr) begin
         // Registers are read-only, so a write gets an answer and RDATA_UNMAPPED as read data
         next_state.rdata = RDATA_UNMAPPED;
      end
   end

   // Bus answer register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state.rdata <= RDATA_UNMAPPED;
         state.ack <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign reg_ack = state.ack;

endmodule

/* File: hw/peak_pkg.sv */
package peak_pkg;

   // Register port widths
   localparam int ADDR_W = 8;
   localparam int BYTE_W = 8;
   localparam int PEAK_W = 2 * BYTE_W;

   // Tracked channels and converter channel select width
   localparam int NUM_CH = 4;
   localparam int CH_IDX_W = 2;
   localparam int CONV_CH_W = 3;

   // Peak register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH0_LOW = 8'h60;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH0_HIGH = 8'h61;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH1_LOW = 8'h62;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH1_HIGH = 8'h63;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH2_LOW = 8'h64;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH2_HIGH = 8'h65;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH3_LOW = 8'h66;
   localparam logic [ADDR_W-1:0] ADDR_PEAK_CH3_HIGH = 8'h67;

   // Span of the peak block, two bytes per channel
   localparam logic [ADDR_W-1:0] PEAK_SPAN = 8'h08;

   // Reset and idle values
   localparam logic [PEAK_W-1:0] PEAK_RESET = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_CLEAR = 8'h00;
   localparam logic [BYTE_W-1:0] RDATA_UNMAPPED = 8'h00;

   // Result of decoding a register address
   typedef struct packed {
      logic hit;
      logic [CH_IDX_W-1:0] ch;
      logic high;
   } peak_decode_t;

endpackage
